// file: rtl/hz_sysctl_hazard.sv
/*
  System-control coprocessor state and its hazard timing. Each issued
  instruction or event walks a fixed pipe; sources are sampled and
  destinations written in the documented hazard cycles.
  Assumes the core issues at most one item per cycle and that software
  keeps the required spacing, since nothing here interlocks.
*/
module hz_sysctl_hazard #(
  parameter int TRACE_STALL_CYC = 4
) (
  // Clock and reset
  input  wire logic                          sys_clk,
  input  wire logic                          reset_n,
  // Issue stream, cycle 1 of each item
  input  wire hz_pkg::hz_issue_type          issue,
  // Interrupt request pins
  input  wire logic [hz_pkg::IP_W-1:0]       intr_pending,
  // Translation buffer
  output hz_pkg::hz_xlat_req_type            xlat_req,
  output logic                               xlat_commit,
  input  wire hz_pkg::hz_xlat_entry_type     xlat_rd_entry,
  input  wire logic [hz_pkg::DATA_W-1:0]     xlat_probe_index,
  // Cache tags and lines
  input  wire hz_pkg::hz_tag_type            cache_tag_in,
  output hz_pkg::hz_tag_type                 cache_tag_out,
  output logic                               cache_tag_store,
  output logic                               cache_line_rd,
  output logic                               cache_line_wr,
  // Register read and return
  output logic                               mfc_valid,
  output logic [hz_pkg::DATA_W-1:0]          mfc_data,
  output logic                               exception_return_valid,
  output logic [hz_pkg::DATA_W-1:0]          exception_return_target,
  // Sampled contexts and checks
  output hz_pkg::hz_mode_type                fetch_ctx,
  output logic                               fetch_uncached,
  output logic                               ls_valid,
  output hz_pkg::hz_ls_ctx_type              ls_ctx,
  output logic                               cu_fault,
  output logic                               intr_req,
  output logic                               trace_stall
);
  import hz_pkg::*;

  hz_issue_type                  stg        [1:STG_LAST];
  logic [$bits(hz_issue_type)-1:0] taps     [STG_LAST-1];
  logic [DATA_W-1:0]             regs_q     [NUM_REGS];
  logic [DATA_W-1:0]             regs_next  [NUM_REGS];
  logic [NUM_REGS-1:0]           regs_we;
  logic [DATA_W-1:0]             status, config_w, entry_hi, cause;
  logic [IP_W-1:0]               ip_meta_reg, ip_sync_reg;
  logic                          exc_in_flight;
  logic                          prev_trace_set_reg, trace_trig;
  logic [STALL_W-1:0]            stall_cnt_reg;
  hz_xlat_req_type               xlat_req_reg;
  hz_tag_type                    tag_out_reg;
  hz_mode_type                   fetch_ctx_reg;
  hz_ls_ctx_type                 ls_ctx_reg;
  logic [DATA_W-1:0]             exception_return_target_reg;
  logic xlat_commit_reg, tag_store_reg, line_rd_reg, line_wr_reg, mfc_valid_reg;
  logic exception_return_valid_reg, uncached_reg, ls_valid_reg, cu_fault_reg, intr_req_reg;
  logic trace_stall_reg;

  function automatic logic is_op(input hz_issue_type s, input hz_op_type o);
    return s.valid && (s.op == o);
  endfunction : is_op

  function automatic hz_mode_type mode_of(input logic [DATA_W-1:0] st,
                                          input logic [DATA_W-1:0] cf,
                                          input logic [DATA_W-1:0] eh);
    hz_mode_type m;
    m.address_space_id = eh[EH_ADDRESS_SPACE_ID_MSB:EH_ADDRESS_SPACE_ID_LSB];
    m.privilege_level  = st[ST_KSU_MSB:ST_KSU_LSB];
    m.exception_level  = st[ST_EXL];
    m.error_level  = st[ST_ERL];
    m.re   = st[ST_RE];
    m.k0   = cf[CF_K0_MSB:CF_K0_LSB];
    return m;
  endfunction : mode_of

  // Pipe advances every cycle; no dependency ever holds it
  hz_delay #(
    .WIDTH ($bits(hz_issue_type)),
    .DEPTH (STG_LAST - 1)
  ) u_pipe (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .din     (issue),
    .taps    (taps)
  );

  always_comb begin
    stg[1] = issue;
    for (int k = 2; k <= STG_LAST; k++) begin
      stg[k] = hz_issue_type'(taps[k-2]);
    end
  end

  hz_regfile #(
    .NREGS (NUM_REGS),
    .WIDTH (DATA_W),
    .IDX_W (IDX_W)
  ) u_regs (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .wr_en   (regs_we),
    .wr_data (regs_next),
    .rd_idx  (stg[MOVE_FROM_SRC].reg_idx),
    .rd_data (mfc_data),
    .regs    (regs_q)
  );

  assign status   = regs_q[REG_STATUS];
  assign config_w = regs_q[REG_CONFIG];
  assign entry_hi = regs_q[REG_ENTRY_HI];
  assign cause    = regs_q[REG_CAUSE];

  // Software write first, hardware events after so they win on conflict
  always_comb begin
    regs_next = regs_q;
    regs_we   = '0;
    if (is_op(stg[MOVE_TO_DST-1], OP_MOVE_TO)) begin
      regs_next[stg[MOVE_TO_DST-1].reg_idx] = stg[MOVE_TO_DST-1].wdata;
      regs_we[stg[MOVE_TO_DST-1].reg_idx]   = 1'b1;
    end
    if (is_op(stg[XLAT_DST-1], OP_XLAT_READ)) begin
      regs_next[REG_PAGE_MASK] = xlat_rd_entry.page_mask;
      regs_next[REG_ENTRY_HI]  = xlat_rd_entry.entry_hi;
      regs_next[REG_ENTRY_LO0] = xlat_rd_entry.entry_lo0;
      regs_next[REG_ENTRY_LO1] = xlat_rd_entry.entry_lo1;
      regs_we[REG_PAGE_MASK]   = 1'b1;
      regs_we[REG_ENTRY_HI]    = 1'b1;
      regs_we[REG_ENTRY_LO0]   = 1'b1;
      regs_we[REG_ENTRY_LO1]   = 1'b1;
    end
    if (is_op(stg[PROBE_DST-1], OP_XLAT_PROBE)) begin
      regs_next[REG_INDEX] = xlat_probe_index;
      regs_we[REG_INDEX]   = 1'b1;
    end
    if (is_op(stg[TAG_LOAD_DST-1], OP_TAG_LOAD)) begin
      regs_next[REG_TAG_LO]     = cache_tag_in.tag_lo;
      regs_next[REG_TAG_HI]     = cache_tag_in.tag_hi;
      regs_next[REG_PARITY_ERR] = cache_tag_in.parity;
      regs_we[REG_TAG_LO]       = 1'b1;
      regs_we[REG_TAG_HI]       = 1'b1;
      regs_we[REG_PARITY_ERR]   = 1'b1;
    end
    // Return clears error_level if set, else exception_level
    if (is_op(stg[EXCEPTION_RETURN_DST-1], OP_EXC_RETURN)) begin
      if (regs_next[REG_STATUS][ST_ERL]) begin
        regs_next[REG_STATUS][ST_ERL] = 1'b0;
      end else begin
        regs_next[REG_STATUS][ST_EXL] = 1'b0;
      end
      regs_we[REG_STATUS] = 1'b1;
    end
    // Fetch faults record pc and level one cycle earlier
    if (is_op(stg[IF_EXC_EARLY_DST-1], OP_IF_EXC)) begin
      regs_next[REG_EXC_PC]         = stg[IF_EXC_EARLY_DST-1].pc;
      regs_next[REG_STATUS][ST_EXL] = 1'b1;
      regs_we[REG_EXC_PC]           = 1'b1;
      regs_we[REG_STATUS]           = 1'b1;
    end
    if (is_op(stg[LS_EXC_DST-1], OP_LS_EXC)) begin
      regs_next[REG_EXC_PC]         = stg[LS_EXC_DST-1].pc;
      regs_next[REG_STATUS][ST_EXL] = 1'b1;
      regs_we[REG_EXC_PC]           = 1'b1;
      regs_we[REG_STATUS]           = 1'b1;
    end
    // Both fault kinds land their address registers in the same cycle
    if (is_op(stg[LS_EXC_DST-1], OP_LS_EXC) || is_op(stg[IF_EXC_DST-1], OP_IF_EXC)) begin
      regs_next[REG_CAUSE][CA_EXC_MSB:CA_EXC_LSB] = stg[IF_EXC_DST-1].exc_code;
      regs_next[REG_BAD_VADDR] = stg[IF_EXC_DST-1].wdata;
      regs_next[REG_CONTEXT][CTX_VPN_MSB:CTX_VPN_LSB] =
        stg[IF_EXC_DST-1].wdata[VA_CTX_MSB:VA_VPN_LSB];
      regs_next[REG_WIDE_PTE][XCTX_VPN_MSB:XCTX_VPN_LSB] =
        stg[IF_EXC_DST-1].wdata[VA_XCTX_MSB:VA_VPN_LSB];
      regs_we[REG_CAUSE]     = 1'b1;
      regs_we[REG_BAD_VADDR] = 1'b1;
      regs_we[REG_CONTEXT]   = 1'b1;
      regs_we[REG_WIDE_PTE]  = 1'b1;
    end
    if (is_op(stg[TS_INST_DST-1], OP_TS_INST) || is_op(stg[TS_DATA_DST-1], OP_TS_DATA)) begin
      regs_next[REG_STATUS][ST_TS] = 1'b1;
      regs_we[REG_STATUS]          = 1'b1;
    end
    // Pending lines always overwrite the pending field
    regs_next[REG_CAUSE][CA_IP_MSB:CA_IP_LSB] = ip_sync_reg;
    regs_we[REG_CAUSE] = 1'b1;
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ip_meta_reg <= '0;
      ip_sync_reg <= '0;
    end else begin
      ip_meta_reg <= intr_pending;
      ip_sync_reg <= ip_meta_reg;
    end
  end

  // Move-from reads in cycle 3; a move-to right before it is illegal
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      mfc_valid_reg <= 1'b0;
    end else begin
      mfc_valid_reg <= is_op(stg[MOVE_FROM_SRC], OP_MOVE_FROM);
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      xlat_req_reg    <= '0;
      xlat_commit_reg <= 1'b0;
    end else begin
      xlat_req_reg.read       <= is_op(stg[XLAT_SRC], OP_XLAT_READ);
      xlat_req_reg.write      <= is_op(stg[XLAT_SRC], OP_XLAT_WRITE_IDX) ||
                                 is_op(stg[XLAT_SRC], OP_XLAT_WRITE_RAND);
      xlat_req_reg.probe      <= is_op(stg[XLAT_SRC], OP_XLAT_PROBE);
      xlat_req_reg.use_random <= is_op(stg[XLAT_SRC], OP_XLAT_WRITE_RAND);
      xlat_req_reg.index      <= is_op(stg[XLAT_SRC], OP_XLAT_WRITE_RAND) ?
                                 regs_q[REG_RANDOM] : regs_q[REG_INDEX];
      xlat_req_reg.entry      <= {regs_q[REG_PAGE_MASK], entry_hi,
                                  regs_q[REG_ENTRY_LO0], regs_q[REG_ENTRY_LO1]};
      xlat_commit_reg <= is_op(stg[XLAT_DST-1], OP_XLAT_WRITE_IDX) ||
                         is_op(stg[XLAT_DST-1], OP_XLAT_WRITE_RAND);
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      exception_return_valid_reg  <= 1'b0;
      exception_return_target_reg <= '0;
    end else begin
      exception_return_valid_reg  <= is_op(stg[EXCEPTION_RETURN_SRC], OP_EXC_RETURN);
      exception_return_target_reg <= status[ST_ERL] ? regs_q[REG_ERROR_PC] : regs_q[REG_EXC_PC];
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      tag_store_reg <= 1'b0;
      tag_out_reg   <= '0;
      line_rd_reg   <= 1'b0;
      line_wr_reg   <= 1'b0;
    end else begin
      tag_store_reg <= is_op(stg[TAG_STORE_SRC], OP_TAG_STORE);
      tag_out_reg   <= {regs_q[REG_TAG_LO], regs_q[REG_TAG_HI], regs_q[REG_PARITY_ERR]};
      line_rd_reg   <= is_op(stg[HIT_RD_SRC], OP_CACHE_HIT);
      line_wr_reg   <= is_op(stg[HIT_WR_DST-1], OP_CACHE_HIT);
    end
  end

  // Config writes at 5 against fetch sampling at 2: third fetch after the move
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      fetch_ctx_reg <= '0;
      uncached_reg  <= 1'b0;
      cu_fault_reg  <= 1'b0;
    end else begin
      if (stg[FETCH_SRC].valid) begin
        fetch_ctx_reg <= mode_of(status, config_w, entry_hi);
        uncached_reg  <= config_w[CF_K0_MSB:CF_K0_LSB] == K0_UNCACHED;
      end
      cu_fault_reg <= is_op(stg[CU_SRC], OP_COPROC) && !status[ST_CU0] &&
                      status[ST_KSU_MSB:ST_KSU_LSB] != KSU_KERNEL &&
                      !status[ST_EXL] && !status[ST_ERL];
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ls_valid_reg <= 1'b0;
      ls_ctx_reg   <= '0;
    end else begin
      ls_valid_reg <= is_op(stg[LS_SRC], OP_LOAD) || is_op(stg[LS_SRC], OP_STORE);
      if (is_op(stg[LS_SRC], OP_LOAD) || is_op(stg[LS_SRC], OP_STORE)) begin
        ls_ctx_reg.mode     <= mode_of(status, config_w, entry_hi);
        ls_ctx_reg.ad       <= config_w[CF_AD];
        ls_ctx_reg.ep       <= config_w[CF_EP_MSB:CF_EP_LSB];
        ls_ctx_reg.watch_lo <= regs_q[REG_WATCH_LO];
        ls_ctx_reg.watch_hi <= regs_q[REG_WATCH_HI];
      end
    end
  end

  // No recognition while a flow change is in the pipe; latency is not promised there
  always_comb begin
    exc_in_flight = 1'b0;
    for (int k = 1; k <= STG_LAST; k++) begin
      if (is_op(stg[k], OP_LS_EXC) || is_op(stg[k], OP_IF_EXC) || is_op(stg[k], OP_EXC_RETURN)) begin
        exc_in_flight = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      intr_req_reg <= 1'b0;
    end else begin
      intr_req_reg <= |(cause[CA_IP_MSB:CA_IP_LSB] & status[ST_IM_MSB:ST_IM_LSB]) &&
                      status[ST_IE] && !status[ST_EXL] && !status[ST_ERL] &&
                      !exc_in_flight;
    end
  end

  // Only stall in the unit: branch right after trace bit set
  assign trace_trig = issue.valid && issue.branch && prev_trace_set_reg;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      prev_trace_set_reg <= 1'b0;
      stall_cnt_reg      <= '0;
      trace_stall_reg    <= 1'b0;
    end else begin
      prev_trace_set_reg <= is_op(issue, OP_MOVE_TO) && issue.reg_idx == REG_STATUS &&
                            issue.wdata[ST_TRACE];
      if (trace_trig) begin
        stall_cnt_reg <= STALL_W'(TRACE_STALL_CYC);
      end else if (stall_cnt_reg != '0) begin
        stall_cnt_reg <= stall_cnt_reg - STALL_W'(1);
      end
      trace_stall_reg <= trace_trig || stall_cnt_reg > STALL_W'(1);
    end
  end

  assign xlat_req        = xlat_req_reg;
  assign xlat_commit     = xlat_commit_reg;
  assign cache_tag_out   = tag_out_reg;
  assign cache_tag_store = tag_store_reg;
  assign cache_line_rd   = line_rd_reg;
  assign cache_line_wr   = line_wr_reg;
  assign mfc_valid       = mfc_valid_reg;
  assign exception_return_valid      = exception_return_valid_reg;
  assign exception_return_target     = exception_return_target_reg;
  assign fetch_ctx       = fetch_ctx_reg;
  assign fetch_uncached  = uncached_reg;
  assign ls_valid        = ls_valid_reg;
  assign ls_ctx          = ls_ctx_reg;
  assign cu_fault        = cu_fault_reg;
  assign intr_req        = intr_req_reg;
  assign trace_stall     = trace_stall_reg;
endmodule : hz_sysctl_hazard

// file: rtl/hz_pkg.sv
/*
  Shared constants and types for the system-control coprocessor hazard
  timing unit: register indices, field positions, hazard cycle numbers,
  operation codes and the packed carriers between the unit and the core.
  Assumes one issued instruction or event per sys_clk cycle.
*/
// Operation
// - Move-to write lands, visible at cycle 5
// - Move-from samples its register at cycle 3
// - No interlock stalls for coprocessor dependencies
// - Xlat read samples at 2, writes at 5
// - Xlat writes sample at 2, entry usable 5
// - Probe samples at 2, index ready 6
// - Exception return samples at 2, clears at 4
// - Tag load writes tag registers by 5
// - Tag store samples 3; hit ops 3/5
// - Loads and stores sample their context at 3
// - Load/store exception registers ready at 5
// - Fetch exception: pc/status 4, rest 5
// - Instruction fetch samples its context at 2
// - Coprocessor-usable check evaluates at cycle 2
// - Interrupt sampling reads its inputs at 2
// - Shutdown flag after 2 inst, 4 data
// - Uncached from third fetch after move
// - Branch after trace bit set stalls
// - Enable-to-interrupt latency undefined around exceptions
package hz_pkg;
  localparam int DATA_W  = 64;
  localparam int IDX_W   = 5;
  localparam int NUM_REGS = 32;
  localparam int IP_W    = 8;
  localparam int STALL_W = 8;

  // Register indices
  localparam logic [IDX_W-1:0] REG_INDEX      = 5'h00;
  localparam logic [IDX_W-1:0] REG_RANDOM     = 5'h01;
  localparam logic [IDX_W-1:0] REG_ENTRY_LO0  = 5'h02;
  localparam logic [IDX_W-1:0] REG_ENTRY_LO1  = 5'h03;
  localparam logic [IDX_W-1:0] REG_CONTEXT    = 5'h04;
  localparam logic [IDX_W-1:0] REG_PAGE_MASK  = 5'h05;
  localparam logic [IDX_W-1:0] REG_BAD_VADDR  = 5'h08;
  localparam logic [IDX_W-1:0] REG_ENTRY_HI   = 5'h0A;
  localparam logic [IDX_W-1:0] REG_STATUS     = 5'h0C;
  localparam logic [IDX_W-1:0] REG_CAUSE      = 5'h0D;
  localparam logic [IDX_W-1:0] REG_EXC_PC     = 5'h0E;
  localparam logic [IDX_W-1:0] REG_CONFIG     = 5'h10;
  localparam logic [IDX_W-1:0] REG_WATCH_LO   = 5'h12;
  localparam logic [IDX_W-1:0] REG_WATCH_HI   = 5'h13;
  localparam logic [IDX_W-1:0] REG_WIDE_PTE   = 5'h14;
  localparam logic [IDX_W-1:0] REG_PARITY_ERR = 5'h1A;
  localparam logic [IDX_W-1:0] REG_TAG_LO     = 5'h1C;
  localparam logic [IDX_W-1:0] REG_TAG_HI     = 5'h1D;
  localparam logic [IDX_W-1:0] REG_ERROR_PC   = 5'h1E;

  // Field positions
  localparam int ST_IE = 0, ST_EXL = 1, ST_ERL = 2, ST_KSU_LSB = 3, ST_KSU_MSB = 4;
  localparam int ST_IM_LSB = 8, ST_IM_MSB = 15, ST_TS = 21, ST_TRACE = 24, ST_RE = 25;
  localparam int ST_CU0 = 28;
  localparam int CF_K0_LSB = 0, CF_K0_MSB = 2, CF_AD = 23, CF_EP_LSB = 24, CF_EP_MSB = 27;
  localparam int CA_EXC_LSB = 2, CA_EXC_MSB = 6, CA_IP_LSB = 8, CA_IP_MSB = 15;
  localparam int EH_ADDRESS_SPACE_ID_LSB = 0, EH_ADDRESS_SPACE_ID_MSB = 7;
  localparam int CTX_VPN_LSB = 4, CTX_VPN_MSB = 22, XCTX_VPN_LSB = 4, XCTX_VPN_MSB = 30;
  localparam int VA_VPN_LSB = 13, VA_CTX_MSB = 31, VA_XCTX_MSB = 39;
  localparam logic [2:0] K0_UNCACHED = 3'h2;
  localparam logic [1:0] KSU_KERNEL  = 2'h0;

  // Hazard cycles: sources sampled in that cycle, destinations visible in it
  localparam int MOVE_TO_DST = 5, MOVE_FROM_SRC = 3;
  localparam int XLAT_SRC = 2, XLAT_DST = 5, PROBE_DST = 6;
  localparam int EXCEPTION_RETURN_SRC = 2, EXCEPTION_RETURN_DST = 4;
  localparam int TAG_LOAD_DST = 5, TAG_STORE_SRC = 3, HIT_RD_SRC = 3, HIT_WR_DST = 5;
  localparam int LS_SRC = 3, LS_EXC_DST = 5, IF_EXC_EARLY_DST = 4, IF_EXC_DST = 5;
  localparam int FETCH_SRC = 2, CU_SRC = 2, INTR_SRC = 2;
  localparam int TS_INST_DST = 2, TS_DATA_DST = 4;
  localparam int STG_LAST = PROBE_DST - 1;

  typedef enum logic [4:0] {
    OP_NONE = 5'h00, OP_MOVE_TO = 5'h01, OP_MOVE_FROM = 5'h02, OP_XLAT_READ = 5'h03,
    OP_XLAT_WRITE_IDX = 5'h04, OP_XLAT_WRITE_RAND = 5'h05, OP_XLAT_PROBE = 5'h06,
    OP_EXC_RETURN = 5'h07, OP_TAG_LOAD = 5'h08, OP_TAG_STORE = 5'h09, OP_CACHE_HIT = 5'h0A,
    OP_LOAD = 5'h0B, OP_STORE = 5'h0C, OP_COPROC = 5'h0D, OP_LS_EXC = 5'h0E,
    OP_IF_EXC = 5'h0F, OP_TS_INST = 5'h10, OP_TS_DATA = 5'h11
  } hz_op_type;

  typedef struct packed {
    logic              valid;
    hz_op_type         op;
    logic [IDX_W-1:0]  reg_idx;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] pc;
    logic [4:0]        exc_code;
    logic              branch;
  } hz_issue_type;

  typedef struct packed {
    logic [DATA_W-1:0] page_mask;
    logic [DATA_W-1:0] entry_hi;
    logic [DATA_W-1:0] entry_lo0;
    logic [DATA_W-1:0] entry_lo1;
  } hz_xlat_entry_type;

  typedef struct packed {
    logic              read;
    logic              write;
    logic              probe;
    logic              use_random;
    logic [DATA_W-1:0] index;
    hz_xlat_entry_type entry;
  } hz_xlat_req_type;

  typedef struct packed {
    logic [DATA_W-1:0] tag_lo;
    logic [DATA_W-1:0] tag_hi;
    logic [DATA_W-1:0] parity;
  } hz_tag_type;

  typedef struct packed {
    logic [7:0] address_space_id;
    logic [1:0] privilege_level;
    logic       exception_level;
    logic       error_level;
    logic       re;
    logic [2:0] k0;
  } hz_mode_type;

  typedef struct packed {
    hz_mode_type       mode;
    logic              ad;
    logic [3:0]        ep;
    logic [DATA_W-1:0] watch_lo;
    logic [DATA_W-1:0] watch_hi;
  } hz_ls_ctx_type;
endpackage : hz_pkg

// file: rtl/hz_delay.sv
/*
  Fixed-depth delay line: tap k holds the input of k+1 cycles ago.
  Assumes a single clock and that the line never stalls.
*/
module hz_delay #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             reset_n,
  // Data
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] taps [DEPTH]
);
  for (genvar g = 0; g < DEPTH; g++) begin : g_tap
    always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
        taps[g] <= '0;
      end else if (g == 0) begin
        taps[g] <= din;
      end else begin
        taps[g] <= taps[(g == 0) ? 0 : g - 1];
      end
    end
  end
endmodule : hz_delay

// file: rtl/hz_regfile.sv
/*
  Coprocessor register array with one write enable per word and a
  registered read port. All words are also visible in parallel.
  Assumes the owner merges all writers into one next value per word.
*/
module hz_regfile #(
  parameter int NREGS = 32,
  parameter int WIDTH = 64,
  parameter int IDX_W = 5
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             reset_n,
  // Write side
  input  wire logic [NREGS-1:0] wr_en,
  input  wire logic [WIDTH-1:0] wr_data [NREGS],
  // Read side
  input  wire logic [IDX_W-1:0] rd_idx,
  output logic      [WIDTH-1:0] rd_data,
  output logic      [WIDTH-1:0] regs    [NREGS]
);
  for (genvar g = 0; g < NREGS; g++) begin : g_word
    always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
        regs[g] <= '0;
      end else if (wr_en[g]) begin
        regs[g] <= wr_data[g];
      end
    end
  end

  // Read sees the word before any write of the same edge
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_data <= '0;
    end else begin
      rd_data <= regs[rd_idx];
    end
  end
endmodule : hz_regfile

// file: verification/hz_properties.sv
/* Checker of answer latencies for hz_sysctl_hazard.
   Assumes one issued item per cycle and no interlock. */
module hz_chk
  import hz_pkg::*;
(
  // Clock and issue
  input wire logic                    sys_clk,
  input wire logic                    reset_n,
  input wire hz_pkg::hz_issue_type    issue,
  // Answers
  input wire hz_pkg::hz_xlat_req_type xlat_req,
  input wire logic                    xlat_commit,
  input wire logic                    cache_tag_store,
  input wire logic                    cache_line_rd,
  input wire logic                    cache_line_wr,
  input wire logic                    mfc_valid,
  input wire logic                    exception_return_valid,
  input wire logic                    ls_valid
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);
  // Idle slots read as no op
  wire hz_op_type op = issue.valid ? issue.op : OP_NONE;
  sequence s_commit;
    xlat_req.write ##2 xlat_commit;
  endsequence
  sequence s_line;
    cache_line_rd ##1 cache_line_wr;
  endsequence
  property p_mfc; op == OP_MOVE_FROM |-> ##3 mfc_valid; endproperty
  property p_xrd; op == OP_XLAT_READ |-> ##2 xlat_req.read; endproperty
  property p_xwr; op inside {OP_XLAT_WRITE_IDX, OP_XLAT_WRITE_RAND} |-> ##2 s_commit; endproperty
  property p_prb; op == OP_XLAT_PROBE |-> ##2 xlat_req.probe; endproperty
  property p_exception_return; op == OP_EXC_RETURN |-> ##2 exception_return_valid; endproperty
  property p_tag; op == OP_TAG_STORE |-> ##3 cache_tag_store; endproperty
  property p_hit; op == OP_CACHE_HIT |-> ##3 s_line; endproperty
  property p_ls; op inside {OP_LOAD, OP_STORE} |-> ##3 ls_valid; endproperty
  a_mfc: assert property (p_mfc) else $error("move-from answer late");
  a_xrd: assert property (p_xrd) else $error("xlat read late");
  a_xwr: assert property (p_xwr) else $error("xlat write late");
  a_prb: assert property (p_prb) else $error("probe late");
  a_exception_return: assert property (p_exception_return) else $error("return late");
  a_tag: assert property (p_tag) else $error("tag store late");
  a_hit: assert property (p_hit) else $error("hit op late");
  a_ls: assert property (p_ls) else $error("load store late");
endmodule : hz_chk

bind hz_sysctl_hazard hz_chk chk_u (.sys_clk(sys_clk), .reset_n(reset_n), .issue(issue),
  .xlat_req(xlat_req), .xlat_commit(xlat_commit), .cache_tag_store(cache_tag_store),
  .cache_line_rd(cache_line_rd), .cache_line_wr(cache_line_wr), .mfc_valid(mfc_valid),
  .exception_return_valid(exception_return_valid), .ls_valid(ls_valid));

// file: verification/test_hz_sysctl_hazard.sv
/* Bench for hz_sysctl_hazard: move and probe hazard windows, ops xlat read to store,
   interrupt sampling. Assumes hz_chk is bound to the design. */
module test_hz_sysctl_hazard;
  timeunit 1ns;
  timeprecision 1ps;
  import hz_pkg::*;
  logic              sys_clk = 1'b0;
  logic              reset_n = 1'b0;
  hz_issue_type      issue = '0;
  logic [IP_W-1:0]   intr_pending = '0;
  logic [DATA_W-1:0] probe_in = '0;
  logic [DATA_W-1:0] mfc_data, v, old, idx_old, q[$];
  logic              mfc_valid, intr_req, trace_stall;
  logic [31:0]       rnd = 32'h672A;
  int                err_count = 0, cmp_count = 0, cyc = 0;

  hz_sysctl_hazard dut_u (.sys_clk(sys_clk), .reset_n(reset_n), .issue(issue), .intr_pending(intr_pending),
    .xlat_req(), .xlat_commit(), .xlat_rd_entry('0), .xlat_probe_index(probe_in), .cache_tag_in('0),
    .cache_tag_out(), .cache_tag_store(), .cache_line_rd(), .cache_line_wr(), .mfc_valid(mfc_valid),
    .mfc_data(mfc_data), .exception_return_valid(), .exception_return_target(), .fetch_ctx(), .fetch_uncached(), .ls_valid(),
    .ls_ctx(), .cu_fault(), .intr_req(intr_req), .trace_stall(trace_stall));

  always #20 sys_clk = ~sys_clk;

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  task automatic iss(input hz_op_type o, input logic [IDX_W-1:0] r, input logic [DATA_W-1:0] d);
    issue <= '{valid: 1'b1, op: o, reg_idx: r, wdata: d, default: '0};
    @(negedge sys_clk);
  endtask : iss

  task automatic idle(input int n);
    issue <= '0;
    repeat (n) @(negedge sys_clk);
  endtask : idle

  task automatic chk(input string nm, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] s);
    cmp_count++;
    if (s !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic test_done;
    if (err_count == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done

  // Every move-from answer is matched against the model queue
  always @(negedge sys_clk) if (mfc_valid === 1'b1) begin
    if (q.size() == 0) chk("mfc_extra", 64'h0, 64'h1);
    else chk("mfc_data", q.pop_front(), mfc_data);
  end

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc > 1000) begin
      err_count++;
      test_done();
    end
  end

  initial begin
    repeat (5) @(negedge sys_clk);
    reset_n <= 1'b1;
    probe_in <= {rnd, ~rnd};
    @(negedge sys_clk);
    // Each pipe from xlat read to store once, back to back
    // Store comes last, so no cache op follows it on the same line
    for (int k = 3; k <= 12; k++) iss(hz_op_type'(k), '0, {2{rnd}});
    idle(8);
    idx_old = probe_in;
    old = '0;
    // Gap 0 breaks the spacing on purpose and must see the old word
    for (int g = 0; g < 3; g++) begin
      rnd = lfsr(rnd);
      v = {rnd, ~rnd};
      iss(OP_MOVE_TO, 5'h06, v);
      if (g > 0) idle(g);
      iss(OP_MOVE_FROM, 5'h06, '0);
      q.push_back((g >= MOVE_TO_DST - MOVE_FROM_SRC - 1) ? v : old);
      old = v;
      idle(6);
    end
    for (int g = 1; g < 3; g++) begin
      rnd = lfsr(rnd);
      v = {~rnd, rnd};
      probe_in <= v;
      iss(OP_XLAT_PROBE, '0, '0);
      idle(g);
      iss(OP_MOVE_FROM, REG_INDEX, '0);
      q.push_back((g >= PROBE_DST - MOVE_FROM_SRC - 1) ? v : idx_old);
      idx_old = v;
      idle(8);
    end
    // Enable and all mask bits, then raise a pin
    iss(OP_MOVE_TO, REG_STATUS, 64'hFF01);
    idle(6);
    rnd = lfsr(rnd);
    intr_pending <= rnd[7:0] | 8'h01;
    repeat (6) @(negedge sys_clk);
    chk("intr_req", 64'h1, 64'(intr_req));
    intr_pending <= '0;
    repeat (6) @(negedge sys_clk);
    chk("intr_req", 64'h0, 64'(intr_req));
    // Trace bit set, then a branch right after it
    iss(OP_MOVE_TO, REG_STATUS, 64'h100_0000);
    issue <= '{valid: 1'b1, op: OP_NONE, branch: 1'b1, default: '0};
    @(negedge sys_clk);
    issue <= '0;
    chk("trace_stall", 64'h1, 64'(trace_stall));
    repeat (4) @(negedge sys_clk);
    chk("trace_stall", 64'h0, 64'(trace_stall));
    chk("mfc_left", 64'h0, 64'(q.size()));
    test_done();
  end
endmodule : test_hz_sysctl_hazard
